// ===== design/eipl_top.sv
// External interrupt request pin logic with AXI4-Lite register access
//
// Operation
// RULE1 - Bit 6 turns the internal pull device off while the pin is enabled.
// RULE2 - Bit 5 picks falling/low (0) or rising/high (1) as the active sense.
// RULE3 - Pin enabled with rising sense swaps the pull-up for a pull-down.
// RULE4 - Bit 4 enables the request input and turns its pull device on.
// RULE5 - Bit 3 is a read-only flag set when a qualifying event is seen.
// RULE6 - Writing 1 to bit 2 clears the flag, 0 does nothing, it reads as 0.
// RULE7 - In edge-and-level mode the flag holds while the pin is asserted.
// RULE8 - Bit 1 raises a hardware request whenever the flag is set.
// RULE9 - Bit 0 selects edge-only (0) or edge-and-level (1) detection.
// RULE10 - The pin is synchronised and edge-checked; no event while disabled.
// RULE11 - Bit 7 reads 0 and ignores writes; all bits reset to 0.
`timescale 1ns/10ps
module eipl_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic request_pin,
   output eipl_pkg::eipl_pull_s pull_ctl,
   output logic irq,
   input wire logic [eipl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [eipl_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [eipl_pkg::STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [eipl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [eipl_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import eipl_pkg::*;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic eipl_sel_e reg_sel(input logic [ADDR_W-1:0] addr);
      eipl_sel_e sel;
      sel = EIPL_SEL_NONE;
      if (addr == OFS_CTRL) begin
         sel = EIPL_SEL_CTRL;
      end else if (addr == OFS_STATUS) begin
         sel = EIPL_SEL_STATUS;
      end else if (addr == OFS_MASK) begin
         sel = EIPL_SEL_MASK;
      end
      return sel;
   endfunction : reg_sel

   // ****************************************************************
   // Response code
   // ****************************************************************
   function automatic logic [1:0] sel_resp(input eipl_sel_e sel);
      logic [1:0] resp;
      resp = RESP_OKAY;
      if (sel == EIPL_SEL_NONE) begin
         resp = RESP_SLVERR;
      end
      return resp;
   endfunction : sel_resp

   // ****************************************************************
   // State
   // ****************************************************************
   eipl_ctrl_s ctrl;
   logic event_flag;
   logic [EVT_W-1:0] evt_status;
   logic [EVT_W-1:0] evt_mask;
   logic pin_level;
   logic pin_prev;
   logic sync2;
   logic sync3;
   eipl_wr_e wr_state;
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [DATA_W-1:0] w_data;
   logic [STRB_W-1:0] w_strb;

   // ****************************************************************
   // Pin synchronisation and event detection
   // ****************************************************************
   eipl_sync u_eipl_sync (
      .clk(clk),
      .rst(rst),
      .din(request_pin),
      .stage2(sync2),
      .stage3(sync3)
   );

   // A change counts once the last two stages agree
   wire next_pin_level = (sync2 == sync3) ? sync3 : pin_level; // [RULE10]
   wire pin_asserted = (pin_level == ctrl.edge_polarity_select); // [RULE2]
   wire edge_hit = pin_asserted && (pin_prev != pin_level); // [RULE10]
   wire level_hit = ctrl.edge_level_detect_mode && pin_asserted; // [RULE9]
   wire event_hit = ctrl.request_pin_enable
      && (edge_hit || level_hit); // [RULE4] [RULE10]

   // ****************************************************************
   // Write channel decode
   // ****************************************************************
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire wr_do = aw_held && w_held && (wr_state == EIPL_WR_IDLE);
   wire eipl_sel_e wr_sel = reg_sel(aw_addr);
   wire wr_lane0 = wr_do && w_strb[0];
   wire wr_ctrl = wr_lane0 && (wr_sel == EIPL_SEL_CTRL);
   wire wr_mask = wr_lane0 && (wr_sel == EIPL_SEL_MASK);
   wire ack_write = wr_ctrl && w_data[BIT_REQUEST_EVENT_ACK]; // [RULE6]
   wire ack_blocked = ack_write && ctrl.request_pin_enable
      && level_hit; // [RULE7]
   wire [1:0] wr_resp = sel_resp(wr_sel);

   wire next_aw_held = wr_do ? 1'b0 : (aw_held || aw_take);
   wire next_w_held = wr_do ? 1'b0 : (w_held || w_take);
   wire next_bvalid = wr_do ? 1'b1
      : ((s_axi_bvalid && s_axi_bready) ? 1'b0 : s_axi_bvalid);
   wire eipl_wr_e next_wr_state = next_bvalid ? EIPL_WR_RESP : EIPL_WR_IDLE;

   // ****************************************************************
   // Read channel decode
   // ****************************************************************
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire eipl_sel_e rd_sel = reg_sel(s_axi_araddr);
   wire rd_status = ar_take && (rd_sel == EIPL_SEL_STATUS);
   wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

   // Bit 7 and the acknowledge bit always read as zero
   wire [7:0] ctrl_view = {
      1'b0, // [RULE11]
      ctrl.pull_device_disable,
      ctrl.edge_polarity_select,
      ctrl.request_pin_enable,
      event_flag, // [RULE5]
      1'b0, // [RULE6]
      ctrl.request_interrupt_enable,
      ctrl.edge_level_detect_mode
   };
   wire [DATA_W-1:0] rd_value =
      (rd_sel == EIPL_SEL_CTRL) ? {24'h000000, ctrl_view}
      : (rd_sel == EIPL_SEL_STATUS) ? {30'h00000000, evt_status}
      : (rd_sel == EIPL_SEL_MASK) ? {30'h00000000, evt_mask}
      : 32'h00000000;
   wire [1:0] rd_resp = sel_resp(rd_sel);

   // ****************************************************************
   // Control and mask next values
   // ****************************************************************
   // Bit 7 and the acknowledge bit have no storage
   wire eipl_ctrl_s next_ctrl = wr_ctrl ? eipl_ctrl_s'{
      pull_device_disable: w_data[BIT_PULL_DEVICE_DISABLE],
      edge_polarity_select: w_data[BIT_EDGE_POLARITY_SELECT],
      request_pin_enable: w_data[BIT_REQUEST_PIN_ENABLE],
      request_interrupt_enable: w_data[BIT_REQUEST_INTERRUPT_ENABLE],
      edge_level_detect_mode: w_data[BIT_EDGE_LEVEL_DETECT_MODE]
   } : ctrl; // [RULE11]
   wire [EVT_W-1:0] next_evt_mask = wr_mask ? w_data[EVT_W-1:0] : evt_mask;

   // ****************************************************************
   // Flag, sticky status and interrupt
   // ****************************************************************
   // Set wins over the acknowledge clear
   wire next_event_flag = event_hit
      || (event_flag && !ack_write); // [RULE5] [RULE6] [RULE7]

   wire [EVT_W-1:0] evt_set = {ack_blocked, event_hit};
   wire [EVT_W-1:0] next_evt_status = evt_set
      | (rd_status ? EVT_RESET : evt_status);

   wire next_irq = (next_event_flag && next_ctrl.request_interrupt_enable)
      || ((next_evt_status & next_evt_mask) != EVT_RESET); // [RULE8]

   // ****************************************************************
   // Pull device steering
   // ****************************************************************
   wire pull_on = next_ctrl.request_pin_enable
      && !next_ctrl.pull_device_disable; // [RULE1] [RULE4]
   wire eipl_pull_s next_pull = '{
      pull_up_en: pull_on && !next_ctrl.edge_polarity_select,
      pull_down_en: pull_on && next_ctrl.edge_polarity_select // [RULE3]
   };

   // ****************************************************************
   // Control and mask registers
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl <= '0; // [RULE11]
      end else begin
         ctrl <= next_ctrl;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         evt_mask <= EVT_RESET;
      end else begin
         evt_mask <= next_evt_mask;
      end
   end

   // ****************************************************************
   // Pin state
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_level <= 1'b0;
         pin_prev <= 1'b0;
      end else begin
         pin_level <= next_pin_level;
         pin_prev <= pin_level;
      end
   end

   // ****************************************************************
   // Event flag and sticky status
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_flag <= 1'b0; // [RULE11]
         evt_status <= EVT_RESET;
      end else begin
         event_flag <= next_event_flag;
         evt_status <= next_evt_status;
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
         pull_ctl <= '0;
      end else begin
         irq <= next_irq;
         pull_ctl <= next_pull;
      end
   end

   // ****************************************************************
   // AXI4-Lite write channel
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_state <= EIPL_WR_IDLE;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         wr_state <= next_wr_state;
         s_axi_awready <= !next_aw_held && !next_bvalid;
         s_axi_wready <= !next_w_held && !next_bvalid;
         s_axi_bvalid <= next_bvalid;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_do) begin
            s_axi_bresp <= wr_resp;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite read channel
   // ****************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid <= next_rvalid;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rdata <= rd_value;
         s_axi_rresp <= rd_resp;
      end
   end

endmodule : eipl_top

// ===== design/eipl_pkg.sv
// Constants and types shared by the external interrupt pin logic
package eipl_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int SYNC_STAGES = 3;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_MASK = 4'h8;

   // ****************************************************************
   // Control and status register field positions
   // ****************************************************************
   localparam int BIT_PULL_DEVICE_DISABLE = 6;
   localparam int BIT_EDGE_POLARITY_SELECT = 5;
   localparam int BIT_REQUEST_PIN_ENABLE = 4;
   localparam int BIT_REQUEST_EVENT_FLAG = 3;
   localparam int BIT_REQUEST_EVENT_ACK = 2;
   localparam int BIT_REQUEST_INTERRUPT_ENABLE = 1;
   localparam int BIT_EDGE_LEVEL_DETECT_MODE = 0;

   // Sticky event status and mask field positions
   localparam int BIT_EVT_DETECTED = 0;
   localparam int BIT_EVT_ACK_BLOCKED = 1;
   localparam int EVT_W = 2;

   // ****************************************************************
   // Reset values and bus answers
   // ****************************************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic pull_device_disable;
      logic edge_polarity_select;
      logic request_pin_enable;
      logic request_interrupt_enable;
      logic edge_level_detect_mode;
   } eipl_ctrl_s;

   typedef struct packed {
      logic pull_up_en;
      logic pull_down_en;
   } eipl_pull_s;

   typedef enum logic [1:0] {
      EIPL_SEL_CTRL = 2'h0,
      EIPL_SEL_STATUS = 2'h1,
      EIPL_SEL_MASK = 2'h3,
      EIPL_SEL_NONE = 2'h2
   } eipl_sel_e;

   typedef enum logic {
      EIPL_WR_IDLE = 1'h0,
      EIPL_WR_RESP = 1'h1
   } eipl_wr_e;

endpackage : eipl_pkg

// ===== design/eipl_sync.sv
// Three-stage synchroniser for the request pin
`timescale 1ns/10ps
module eipl_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic stage2,
   output logic stage3
);
   import eipl_pkg::*;

   logic [SYNC_STAGES-1:0] chain;

   // First stage is read only by the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chain <= '0;
      end else begin
         chain <= {chain[SYNC_STAGES-2:0], din};
      end
   end

   assign stage2 = chain[1];
   assign stage3 = chain[2];

endmodule : eipl_sync

// ===== testbench/eipl_properties.sv
// Port assertions for the external interrupt pin logic
`timescale 1ns/10ps
module eipl_properties (
   input wire logic clk,
   input wire logic rst,
   input wire eipl_pkg::eipl_pull_s pull_ctl,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [eipl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [eipl_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import eipl_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_pull_one_way: assert property (
      !(pull_ctl.pull_up_en && pull_ctl.pull_down_en))
      else $error("both pull devices on");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer missing");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer missing");
   a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr >= 4'hC |=> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == '0) else $error("unmapped read not refused");
   a_b_retire: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not retired");
   a_r_retire: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not retired");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address open during answer");
   a_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
      else $error("unused read bits set");
   a_ack_reads_zero: assert property (
      s_axi_rvalid |-> !s_axi_rdata[2]) else $error("ack bit reads one");
endmodule : eipl_properties

bind eipl_top eipl_properties u_eipl_properties (
   .clk(clk), .rst(rst), .pull_ctl(pull_ctl),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

// ===== testbench/eipl_pin_dev.sv
// Model of the external device on the request pin
`timescale 1ns/10ps
module eipl_pin_dev (
   input wire logic clk,
   input wire logic drive_en,
   input wire logic drive_val,
   input wire eipl_pkg::eipl_pull_s pull_ctl,
   output logic pin
);
   import eipl_pkg::*;
   logic last;
   always_ff @(posedge clk) begin
      if (drive_en) last <= drive_val;
   end
   // Released pin follows the pull device, else drifts off the last value
   always_comb begin
      if (drive_en) pin = drive_val;
      else if (pull_ctl.pull_up_en) pin = 1'b1;
      else if (pull_ctl.pull_down_en) pin = 1'b0;
      else pin = !last;
   end
endmodule : eipl_pin_dev

// ===== testbench/test_external_interrupt_pin_logic.sv
// Register level tests of the external interrupt pin logic
`timescale 1ns/10ps
module test_external_interrupt_pin_logic;
   import eipl_pkg::*;
   logic clk, rst, pin, irq, dev_en, dev_val;
   eipl_pull_s pull_ctl;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [DATA_W-1:0] wdata, rdata, got;
   logic [STRB_W-1:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [7:0] pc [5] = '{8'h00, 8'h10, 8'h30, 8'h50, 8'h70};
   logic [1:0] pe [5] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h0};
   int bad_count = 0;
   int n_checks = 0;

   eipl_top u_eipl_top (.clk(clk), .rst(rst), .request_pin(pin),
      .pull_ctl(pull_ctl), .irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   eipl_pin_dev u_eipl_pin_dev (.clk(clk), .drive_en(dev_en),
      .drive_val(dev_val), .pull_ctl(pull_ctl), .pin(pin));

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid && !awready || wvalid && !wready);
      do @(posedge clk); while (!bvalid);
      chk("bresp", RESP_OKAY, bresp);
      bready <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      got = rdata;
      chk("rresp", er, rresp);
      rready <= 1'b0;
   endtask : rd

   task rchk(input logic [3:0] a, input logic [31:0] e);
      rd(a, RESP_OKAY);
      chk("rdata", e, got);
   endtask : rchk

   task drive(input logic en, input logic v);
      @(posedge clk);
      dev_en <= en;
      dev_val <= v;
      repeat (8) @(posedge clk);
   endtask : drive

   task test_done;
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      #100us;
      bad_count++;
      test_done();
   end

   initial begin
      rst = 1'b1;
      {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
      wdata = '0;
      wstrb = 4'hF;
      dev_en = 1'b1;
      dev_val = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rchk(OFS_CTRL, 32'h0);
      rchk(OFS_STATUS, 32'h0);
      rchk(OFS_MASK, 32'h0);
      rd(4'hC, RESP_SLVERR);
      chk("rdata", 32'h0, got);
      wr(OFS_CTRL, 32'hFFFF_FFFF);
      rchk(OFS_CTRL, 32'h73);
      wstrb <= 4'hE;
      wr(OFS_CTRL, 32'h0);
      wstrb <= 4'hF;
      rchk(OFS_CTRL, 32'h73);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_CTRL, {24'h0, pc[i]});
         repeat (2) @(posedge clk);
         chk("pull", 32'(pe[i]), 32'(pull_ctl));
      end
      // Edge-only falling sense, interrupt enabled
      wr(OFS_CTRL, 32'h16);
      drive(1'b0, 1'b0);
      rd(OFS_STATUS, RESP_OKAY);
      rchk(OFS_CTRL, 32'h12);
      drive(1'b1, 1'b0);
      rchk(OFS_CTRL, 32'h1A);
      chk("irq", 32'h1, irq);
      wr(OFS_CTRL, 32'h12);
      rchk(OFS_CTRL, 32'h1A);
      wr(OFS_CTRL, 32'h16);
      rchk(OFS_CTRL, 32'h12);
      chk("irq", 32'h0, irq);
      drive(1'b0, 1'b0);
      rchk(OFS_CTRL, 32'h12);
      // Edge-and-level mode holds the flag while the pin is low
      wr(OFS_CTRL, 32'h17);
      drive(1'b1, 1'b0);
      rchk(OFS_CTRL, 32'h1B);
      wr(OFS_CTRL, 32'h17);
      rchk(OFS_CTRL, 32'h1B);
      drive(1'b0, 1'b0);
      wr(OFS_CTRL, 32'h17);
      rchk(OFS_CTRL, 32'h13);
      rchk(OFS_STATUS, 32'h3);
      rchk(OFS_STATUS, 32'h0);
      // Interrupt enable off, then the status mask raises the request
      wr(OFS_CTRL, 32'h14);
      drive(1'b1, 1'b0);
      rchk(OFS_CTRL, 32'h18);
      chk("irq", 32'h0, irq);
      wr(OFS_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq", 32'h1, irq);
      rchk(OFS_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0, irq);
      // Rising sense swaps to the pull-down
      wr(OFS_CTRL, 32'h36);
      drive(1'b0, 1'b0);
      rchk(OFS_CTRL, 32'h32);
      drive(1'b1, 1'b1);
      rchk(OFS_CTRL, 32'h3A);
      chk("irq", 32'h1, irq);
      // Pin function off: no events
      wr(OFS_CTRL, 32'h06);
      rchk(OFS_STATUS, 32'h1);
      drive(1'b1, 1'b0);
      drive(1'b1, 1'b1);
      rchk(OFS_CTRL, 32'h02);
      rchk(OFS_STATUS, 32'h0);
      chk("irq", 32'h0, irq);
      test_done();
   end
endmodule : test_external_interrupt_pin_logic
